// [hw/gpwk_top.sv]
// Top of the GPIO edge interrupt and filtered wake-up block.
// Holds the Avalon-MM register slave, status latches and wake flags.
// Assumes pins are asynchronous and the CPU samples the two levels out.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/100ps
module gpwk_top
    import gpwk_pkg::*;
#(
    parameter int P_MS_CYCLES = MS_CYCLES
) (
    input  wire logic              CLK_SYS,         // System clock, 125 MHz
    input  wire logic              RST_B,           // Async reset, active low
    input  wire logic [ADDR_W-1:0] AVS_ADDRESS,     // Byte address
    input  wire logic              AVS_READ,        // Read request
    input  wire logic              AVS_WRITE,       // Write request
    input  wire logic [31:0]       AVS_WRITEDATA,   // Write data
    input  wire logic [3:0]        AVS_BYTEENABLE,  // Byte lanes
    output logic      [31:0]       AVS_READDATA,    // Read data
    output logic                   AVS_WAITREQUEST, // Stall request
    input  wire logic [7:0]        P0_PIN,          // Port 0 pins
    input  wire logic [7:0]        P1_PIN,          // Port 1 pins
    output logic                   PIN_IRQ,         // Pin interrupt, high
    output logic                   CPU_WAKE_REQ     // CPU wake request, high
);

    // ***************************************************************
    // Elaboration checks
    // ***************************************************************
    generate
        if (P_MS_CYCLES < 2) begin : g_bad_ms
            $error("P_MS_CYCLES must be at least 2");
        end
    endgenerate

    // ***************************************************************
    // Pin edge detection
    // ***************************************************************
    logic [7:0] p0_level;   // Synchronised port 0
    logic [7:0] p1_level;   // Synchronised port 1
    logic [7:0] p0_rise;    // Port 0 rising pulses
    logic [7:0] p1_rise;    // Port 1 rising pulses
    logic [7:0] p0_fall;    // Port 0 falling pulses
    logic [7:0] p1_fall;    // Port 1 falling pulses

    // Port 0 synchroniser and edges
    gpwk_edge_cell #(
        .W      (PORT_W)
    ) u_edge_p0 (
        .clk    (CLK_SYS),
        .rst_b  (RST_B),
        .pin_in (P0_PIN),
        .level  (p0_level),
        .rise   (p0_rise),
        .fall   (p0_fall)
    );

    // Port 1 synchroniser and edges
    gpwk_edge_cell #(
        .W      (PORT_W)
    ) u_edge_p1 (
        .clk    (CLK_SYS),
        .rst_b  (RST_B),
        .pin_in (P1_PIN),
        .level  (p1_level),
        .rise   (p1_rise),
        .fall   (p1_fall)
    );

    // ***************************************************************
    // Avalon-MM slave: one wait cycle, then answer
    // ***************************************************************
    logic              ack_ff, nxt_ack;      // Answer cycle marker
    logic [31:0]       rdata_ff, nxt_rdata;  // Registered read data
    logic              req;                  // Read or write pending
    logic              wr_ok;                // Write takes effect now
    logic [IDX_W-1:0]  idx;                  // Word index
    logic [7:0]        wbyte;                // Lane 0 write data
    logic [31:0]       rd_mux;               // Read selection

    assign req             = AVS_READ | AVS_WRITE;
    assign idx             = AVS_ADDRESS[ADDR_W-1:2];
    assign wbyte           = AVS_WRITEDATA[7:0];
    assign wr_ok           = AVS_WRITE & ack_ff & AVS_BYTEENABLE[0];
    assign AVS_WAITREQUEST = req & ~ack_ff;
    assign AVS_READDATA    = rdata_ff;

    // ***************************************************************
    // Register state
    // ***************************************************************
    logic [7:0] p0_rise_status_ff, nxt_p0_rise_status;     // Rise latches port 0
    logic [7:0] p1_rise_status_ff, nxt_p1_rise_status;     // Rise latches port 1
    logic [7:0] p0_fall_status_ff, nxt_p0_fall_status;     // Fall latches port 0
    logic [7:0] p1_fall_status_ff, nxt_p1_fall_status;     // Fall latches port 1
    logic [7:0] p0_rise_detect_enable_ff, nxt_p0_rise_en;  // Rise enables port 0
    logic [7:0] p1_rise_detect_enable_ff, nxt_p1_rise_en;  // Rise enables port 1
    logic [7:0] p0_fall_detect_enable_ff, nxt_p0_fall_en;  // Fall enables port 0
    logic [7:0] p1_fall_detect_enable_ff, nxt_p1_fall_en;  // Fall enables port 1
    logic [1:0] port_pin_irq_enable_ff, nxt_irq_en;        // Per-port irq enable
    gpwk_cfg_t  cfg_ff, nxt_cfg;                           // Wake configuration
    logic       wake_rise_flag_ff, nxt_wake_rise_flag;     // Filtered rise flag
    logic       wake_fall_flag_ff, nxt_wake_fall_flag;     // Filtered fall flag
    logic       irq_ff, nxt_irq;                           // Registered interrupt
    logic       wake_ff, nxt_wake;                         // Registered wake

    // Write strobes per register
    logic wr_p0_rise;
    logic wr_p1_rise;
    logic wr_p0_fall;
    logic wr_p1_fall;
    logic wr_cfg;
    logic wr_irq_en;

    assign wr_p0_rise = wr_ok && (idx == IDX_P0_RISE);
    assign wr_p1_rise = wr_ok && (idx == IDX_P1_RISE);
    assign wr_p0_fall = wr_ok && (idx == IDX_P0_FALL);
    assign wr_p1_fall = wr_ok && (idx == IDX_P1_FALL);
    assign wr_cfg     = wr_ok && (idx == IDX_WAKE_CFG);
    assign wr_irq_en  = wr_ok && (idx == IDX_PIN_IRQ_EN);

    // ***************************************************************
    // Filtered wake path
    // ***************************************************************
    logic [15:0] all_level;   // Both ports, port 1 high
    logic [15:0] all_rise;
    logic [15:0] all_fall;
    logic        sel_level;   // Selected pin level
    logic        sel_rise;
    logic        sel_fall;
    logic        rise_hit;    // Qualified rising trigger
    logic        fall_hit;    // Qualified falling trigger

    assign all_level = {p1_level, p0_level};
    assign all_rise  = {p1_rise, p0_rise};
    assign all_fall  = {p1_fall, p0_fall};
    assign sel_level = all_level[cfg_ff.wake_source_select];
    assign sel_rise  = all_rise[cfg_ff.wake_source_select];
    assign sel_fall  = all_fall[cfg_ff.wake_source_select];

    // Noise filter for the one selected pin
    gpwk_wake_filter #(
        .P_MS_CYCLES (P_MS_CYCLES)
    ) u_filter (
        .clk         (CLK_SYS),
        .rst_b       (RST_B),
        .level       (sel_level),
        .rise_ev     (sel_rise),
        .fall_ev     (sel_fall),
        .rise_en     (cfg_ff.wake_rise_enable),
        .fall_en     (cfg_ff.wake_fall_enable),
        .filt_sel    (cfg_ff.filter_time_select),
        .rise_hit    (rise_hit),
        .fall_hit    (fall_hit)
    );

    // ***************************************************************
    // Read data selection
    // ***************************************************************
    // Status reads back, enables are write-only at the same address
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (idx)
            IDX_P0_RISE:    rd_mux[7:0] = p0_rise_status_ff;
            IDX_P1_RISE:    rd_mux[7:0] = p1_rise_status_ff;
            IDX_P0_FALL:    rd_mux[7:0] = p0_fall_status_ff;
            IDX_P1_FALL:    rd_mux[7:0] = p1_fall_status_ff;
            IDX_WAKE_CFG:   rd_mux[7:0] = {wake_rise_flag_ff,
                                           wake_fall_flag_ff,
                                           cfg_ff.filter_time_select,
                                           cfg_ff.wake_source_select};
            IDX_PIN_IRQ_EN: rd_mux[1:0] = port_pin_irq_enable_ff;
            default:        rd_mux      = 32'h0000_0000;  // Unmapped reads zero
        endcase
    end

    // Bus handshake next values
    always_comb begin
        nxt_ack   = req & ~ack_ff;
        nxt_rdata = (AVS_READ & ~ack_ff) ? rd_mux : rdata_ff;
    end

    // ***************************************************************
    // Status, enables, flags: next values
    // ***************************************************************
    // Set wins over clear so an edge in the clearing cycle is kept
    always_comb begin
        nxt_p0_rise_en = wr_p0_rise ? wbyte : p0_rise_detect_enable_ff;
        nxt_p1_rise_en = wr_p1_rise ? wbyte : p1_rise_detect_enable_ff;
        nxt_p0_fall_en = wr_p0_fall ? wbyte : p0_fall_detect_enable_ff;
        nxt_p1_fall_en = wr_p1_fall ? wbyte : p1_fall_detect_enable_ff;
        nxt_irq_en     = wr_irq_en ? wbyte[1:0] : port_pin_irq_enable_ff;

        // Clear on written zero, set on enabled edge
        nxt_p0_rise_status = (p0_rise_status_ff & ~(wr_p0_rise ? ~wbyte : 8'h00))
                           | (p0_rise & p0_rise_detect_enable_ff);
        nxt_p1_rise_status = (p1_rise_status_ff & ~(wr_p1_rise ? ~wbyte : 8'h00))
                           | (p1_rise & p1_rise_detect_enable_ff);
        nxt_p0_fall_status = (p0_fall_status_ff & ~(wr_p0_fall ? ~wbyte : 8'h00))
                           | (p0_fall & p0_fall_detect_enable_ff);
        nxt_p1_fall_status = (p1_fall_status_ff & ~(wr_p1_fall ? ~wbyte : 8'h00))
                           | (p1_fall & p1_fall_detect_enable_ff);

        // Wake configuration fields
        nxt_cfg = cfg_ff;
        if (wr_cfg) begin
            nxt_cfg.wake_rise_enable   = wbyte[CFG_RISE_BIT];
            nxt_cfg.wake_fall_enable   = wbyte[CFG_FALL_BIT];
            nxt_cfg.filter_time_select = wbyte[CFG_FILT_LSB +: 2];
            nxt_cfg.wake_source_select = wbyte[CFG_SRC_LSB +: 4];
        end

        // Wake flags: only a written zero enable clears them
        nxt_wake_rise_flag = rise_hit
                           | (wake_rise_flag_ff & ~(wr_cfg & ~wbyte[CFG_RISE_BIT]));
        nxt_wake_fall_flag = fall_hit
                           | (wake_fall_flag_ff & ~(wr_cfg & ~wbyte[CFG_FALL_BIT]));

        // Interrupt from latched status gated per port
        nxt_irq = (|(p0_rise_status_ff | p0_fall_status_ff) & port_pin_irq_enable_ff[0])
                | (|(p1_rise_status_ff | p1_fall_status_ff) & port_pin_irq_enable_ff[1]);

        // Wake on any enabled edge interrupt or filtered flag
        nxt_wake = nxt_irq
                 | wake_rise_flag_ff | wake_fall_flag_ff;
    end

    // ***************************************************************
    // Register everything
    // ***************************************************************
    // All state clears at reset so every source starts disabled
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ack_ff                   <= 1'b0;
            rdata_ff                 <= 32'h0000_0000;
            p0_rise_status_ff        <= REG_RESET;
            p1_rise_status_ff        <= REG_RESET;
            p0_fall_status_ff        <= REG_RESET;
            p1_fall_status_ff        <= REG_RESET;
            p0_rise_detect_enable_ff <= REG_RESET;
            p1_rise_detect_enable_ff <= REG_RESET;
            p0_fall_detect_enable_ff <= REG_RESET;
            p1_fall_detect_enable_ff <= REG_RESET;
            port_pin_irq_enable_ff   <= IRQ_EN_RESET;
            cfg_ff                   <= REG_RESET;
            wake_rise_flag_ff        <= 1'b0;
            wake_fall_flag_ff        <= 1'b0;
            irq_ff                   <= 1'b0;
            wake_ff                  <= 1'b0;
        end else begin
            ack_ff                   <= nxt_ack;
            rdata_ff                 <= nxt_rdata;
            p0_rise_status_ff        <= nxt_p0_rise_status;
            p1_rise_status_ff        <= nxt_p1_rise_status;
            p0_fall_status_ff        <= nxt_p0_fall_status;
            p1_fall_status_ff        <= nxt_p1_fall_status;
            p0_rise_detect_enable_ff <= nxt_p0_rise_en;
            p1_rise_detect_enable_ff <= nxt_p1_rise_en;
            p0_fall_detect_enable_ff <= nxt_p0_fall_en;
            p1_fall_detect_enable_ff <= nxt_p1_fall_en;
            port_pin_irq_enable_ff   <= nxt_irq_en;
            cfg_ff                   <= nxt_cfg;
            wake_rise_flag_ff        <= nxt_wake_rise_flag;
            wake_fall_flag_ff        <= nxt_wake_fall_flag;
            irq_ff                   <= nxt_irq;
            wake_ff                  <= nxt_wake;
        end
    end

    // Registered outputs avoid glitches on the wake line
    assign PIN_IRQ      = irq_ff;
    assign CPU_WAKE_REQ = wake_ff;

endmodule

// [hw/gpwk_pkg.sv]
// Constants, register map and shared types for the GPIO edge and wake-up block.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM slave with byte addresses.
package gpwk_pkg;

    // ***************************************************************
    // Register map: printed offsets are word indices, byte = 4 x index
    // ***************************************************************
    localparam int         ADDR_W          = 18;
    localparam int         IDX_W           = 16;
    localparam logic [15:0] IDX_P0_RISE     = 16'hA028;
    localparam logic [15:0] IDX_P1_RISE     = 16'hA029;
    localparam logic [15:0] IDX_WAKE_CFG    = 16'hA02E;
    localparam logic [15:0] IDX_P0_FALL     = 16'hA038;
    localparam logic [15:0] IDX_P1_FALL     = 16'hA039;
    localparam logic [15:0] IDX_PIN_IRQ_EN  = 16'hA030;
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [1:0]  IRQ_EN_RESET    = 2'h0;

    // ***************************************************************
    // Wake configuration field layout
    // ***************************************************************
    localparam int CFG_RISE_BIT = 7;
    localparam int CFG_FALL_BIT = 6;
    localparam int CFG_FILT_LSB = 4;
    localparam int CFG_SRC_LSB  = 0;

    // Wake configuration as stored
    typedef struct packed {
        logic       wake_rise_enable;   // Bit 7 on write
        logic       wake_fall_enable;   // Bit 6 on write
        logic [1:0] filter_time_select; // 1, 2, 4 or 8 ms
        logic [3:0] wake_source_select; // 0-7 port 0, 8-15 port 1
    } gpwk_cfg_t;

    // ***************************************************************
    // Timing: filter base unit and its cycle count
    // ***************************************************************
    localparam int FILT_BASE_MS   = 1;
    localparam int CLK_FREQ_KHZ   = 125000;
    localparam int MS_CYCLES      = FILT_BASE_MS * CLK_FREQ_KHZ;
    localparam int PORT_W         = 8;

    // Filter sequencer states
    typedef enum logic [1:0] {
        GPWK_IDLE,
        GPWK_QUAL_RISE,
        GPWK_QUAL_FALL
    } gpwk_filt_state_t;

endpackage

// [hw/gpwk_edge_cell.sv]
// Pin synchroniser and edge detector for one port of pins.
// Assumes pins are asynchronous to CLK_SYS; outputs are in the clock domain.
`timescale 1ns/100ps
module gpwk_edge_cell
    import gpwk_pkg::*;
#(
    parameter int W = PORT_W
) (
    input  wire logic         clk,    // System clock
    input  wire logic         rst_b,  // Async reset, active low
    input  wire logic [W-1:0] pin_in, // Raw pins
    output logic      [W-1:0] level,  // Synchronised level
    output logic      [W-1:0] rise,   // One-cycle rising pulse
    output logic      [W-1:0] fall    // One-cycle falling pulse
);

    // ***************************************************************
    // Two-stage synchroniser plus previous sample
    // ***************************************************************
    logic [W-1:0] sync1_ff;     // First stage, read only by sync2
    logic [W-1:0] sync2_ff;     // Stable sample
    logic [W-1:0] prev_ff;      // Sample one cycle older
    logic [W-1:0] nxt_sync1;
    logic [W-1:0] nxt_sync2;
    logic [W-1:0] nxt_prev;

    // Next values of the sample chain
    always_comb begin
        nxt_sync1 = pin_in;
        nxt_sync2 = sync1_ff;
        nxt_prev  = sync2_ff;
    end

    // Register the chain; reset to low, so a pin that is high at release shows a rising edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            prev_ff  <= nxt_prev;
        end
    end

    // Edges from current against previous sample
    assign level = sync2_ff;
    assign rise  = sync2_ff & ~prev_ff;
    assign fall  = ~sync2_ff & prev_ff;

endmodule

// [hw/gpwk_wake_filter.sv]
// Noise filter behind edge detection for the single selected wake pin.
// Assumes level and edge pulses are already synchronous to the clock.
`timescale 1ns/100ps
module gpwk_wake_filter
    import gpwk_pkg::*;
#(
    parameter int P_MS_CYCLES = MS_CYCLES
) (
    input  wire logic       clk,      // System clock
    input  wire logic       rst_b,    // Async reset, active low
    input  wire logic       level,    // Selected pin level
    input  wire logic       rise_ev,  // Selected pin rising pulse
    input  wire logic       fall_ev,  // Selected pin falling pulse
    input  wire logic       rise_en,  // Rising wake enabled
    input  wire logic       fall_en,  // Falling wake enabled
    input  wire logic [1:0] filt_sel, // Filter time code
    output logic            rise_hit, // Qualified rising trigger
    output logic            fall_hit  // Qualified falling trigger
);

    localparam int CYC_W = $clog2(P_MS_CYCLES);

    // ***************************************************************
    // Qualification state and timers
    // ***************************************************************
    gpwk_filt_state_t state_ff, nxt_state;
    logic [CYC_W-1:0] cyc_ff, nxt_cyc;  // Cycles inside current ms
    logic [3:0]       ms_ff, nxt_ms;    // Whole ms of stable level
    logic [3:0]       ms_target;        // 1, 2, 4 or 8
    logic             ms_wrap;          // Last cycle of a ms

    assign ms_target = 4'h1 << filt_sel;
    assign ms_wrap   = (cyc_ff == CYC_W'(P_MS_CYCLES - 1));

    // Next state; restarting the divider at the edge keeps the time exact
    always_comb begin
        nxt_state = state_ff;
        nxt_cyc   = ms_wrap ? '0 : cyc_ff + 1'b1;
        nxt_ms    = ms_wrap ? ms_ff + 4'h1 : ms_ff;
        rise_hit  = 1'b0;
        fall_hit  = 1'b0;
        unique case (state_ff)
            GPWK_IDLE: begin
                nxt_cyc = '0;
                nxt_ms  = 4'h0;
                if (rise_ev && rise_en) begin
                    nxt_state = GPWK_QUAL_RISE;
                end else if (fall_ev && fall_en) begin
                    nxt_state = GPWK_QUAL_FALL;
                end
            end
            GPWK_QUAL_RISE: begin
                if (!rise_en) begin
                    nxt_state = GPWK_IDLE;
                end else if (!level) begin
                    nxt_cyc   = '0;
                    nxt_ms    = 4'h0;
                    nxt_state = fall_en ? GPWK_QUAL_FALL : GPWK_IDLE;
                end else if (ms_wrap && (nxt_ms == ms_target)) begin
                    rise_hit  = 1'b1;
                    nxt_state = GPWK_IDLE;
                end
            end
            GPWK_QUAL_FALL: begin
                if (!fall_en) begin
                    nxt_state = GPWK_IDLE;
                end else if (level) begin
                    nxt_cyc   = '0;
                    nxt_ms    = 4'h0;
                    nxt_state = rise_en ? GPWK_QUAL_RISE : GPWK_IDLE;
                end else if (ms_wrap && (nxt_ms == ms_target)) begin
                    fall_hit  = 1'b1;
                    nxt_state = GPWK_IDLE;
                end
            end
            default: begin
                nxt_state = GPWK_IDLE;
            end
        endcase
    end

    // Register the filter state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= GPWK_IDLE;
            cyc_ff   <= '0;
            ms_ff    <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            cyc_ff   <= nxt_cyc;
            ms_ff    <= nxt_ms;
        end
    end

endmodule

// [testbench/gpwk_checker.sv]
// Port assertions for gpwk_top: bus handshake, latching, wake level.
// Assumes one clock domain and a master that holds requests as required.
`timescale 1ns/100ps
module gpwk_checker (
    input wire logic        CLK_SYS,         // System clock
    input wire logic        RST_B,           // Async reset, active low
    input wire logic        AVS_READ,        // Read request
    input wire logic        AVS_WRITE,       // Write request
    input wire logic [31:0] AVS_READDATA,    // Read data
    input wire logic        AVS_WAITREQUEST, // Stall
    input wire logic        PIN_IRQ,         // Pin interrupt
    input wire logic        CPU_WAKE_REQ     // Wake request
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // Exactly one wait cycle, then a single answer cycle
    property p_rd_wait; $rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_once; !AVS_WAITREQUEST && (AVS_READ || AVS_WRITE)
        |=> AVS_WAITREQUEST || !(AVS_READ || AVS_WRITE); endproperty
    a_once: assert property (p_once) else $error("answer too long");
    property p_idle; !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST; endproperty
    a_idle: assert property (p_idle) else $error("stall while idle");
    property p_hi; AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_rdq; !AVS_READ |=> $stable(AVS_READDATA); endproperty
    a_rdq: assert property (p_rdq) else $error("read data moved");
    property p_irq_wake; PIN_IRQ |-> CPU_WAKE_REQ; endproperty
    a_irq_wake: assert property (p_irq_wake) else $error("irq without wake");
    // Latched sources drop only after a completed write
    property p_irq_hold; PIN_IRQ && !AVS_WRITE && !$past(AVS_WRITE) |=> PIN_IRQ; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_wake_hold; CPU_WAKE_REQ && !PIN_IRQ && !$past(PIN_IRQ) && !AVS_WRITE
        && !$past(AVS_WRITE) |=> CPU_WAKE_REQ; endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake dropped");
    c_irq: cover property ($rose(PIN_IRQ));
    c_wake: cover property (CPU_WAKE_REQ && !PIN_IRQ);
    c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule
bind gpwk_top gpwk_checker i_chk (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .PIN_IRQ(PIN_IRQ), .CPU_WAKE_REQ(CPU_WAKE_REQ));

// [testbench/gpwk_pins.sv]
// External pin model: drives both ports, one clock behind the request.
// Assumes pins are always driven, so no floating level is modelled.
`timescale 1ns/100ps
module gpwk_pins (
    input  wire logic        clk,   // System clock
    input  wire logic [15:0] req,   // Wanted levels, port 1 high byte
    output logic      [7:0]  p0,    // Port 0 pins
    output logic      [7:0]  p1     // Port 1 pins
);
    // Register so pin moves never coincide with the bench edge
    always @(posedge clk) {p1, p0} <= req;
endmodule

// [testbench/gpwk_top_tb.sv]
// Self-checking bench for gpwk_top over Avalon-MM with pin stimulus.
// Assumes a short filter unit of N cycles to keep runs brief.
`timescale 1ns/100ps
module gpwk_top_tb
    import gpwk_pkg::*;
;
    localparam int N = 10;
    logic        clk = 0, rst_b = 0, rd = 0, wr = 0, wq, irq, wake;
    logic [17:0] adr = 0;
    logic [31:0] wd = 0, rdat, q;
    logic [15:0] pr = 0;
    logic [3:0]  be = 4'h1;
    logic [7:0]  p0, p1, c;
    logic [15:0] idx [6] = '{IDX_P0_RISE, IDX_P1_RISE, IDX_WAKE_CFG, IDX_P0_FALL,
                             IDX_P1_FALL, IDX_PIN_IRQ_EN};
    int          n_mismatch = 0, n_checks = 0;
    gpwk_top #(.P_MS_CYCLES(N)) i_dut (.CLK_SYS(clk), .RST_B(rst_b), .AVS_ADDRESS(adr),
        .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .P0_PIN(p0), .P1_PIN(p1),
        .PIN_IRQ(irq), .CPU_WAKE_REQ(wake));
    gpwk_pins i_pins (.clk(clk), .req(pr), .p0(p0), .p1(p1));
    initial forever #4 clk = ~clk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Hold request until waitrequest is sampled low at a rising edge, release there
    task acc(input logic w, input logic [15:0] ix, input logic [7:0] d);
        @(posedge clk);
        adr <= {ix, 2'b00};
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        do @(posedge clk); while (wq !== 1'b0);
        q = rdat;
        wr <= 0;
        rd <= 0;
    endtask
    task rdc(input logic [15:0] ix, input logic [7:0] e);
        acc(0, ix, 8'h00);
        chk(q, {24'h0, e});
    endtask
    task conclude;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1;
        foreach (idx[i]) rdc(idx[i], REG_RESET);
        acc(1, IDX_P0_RISE, 8'hFF);
        acc(1, IDX_PIN_IRQ_EN, 8'h03);
        acc(1, IDX_P1_FALL, 8'h0F);
        pr <= 16'hFFA5;
        repeat (8) @(posedge clk);
        chk(irq, 1);
        chk(wake, 1);
        rdc(IDX_P0_RISE, 8'hA5);
        rdc(IDX_P1_RISE, 8'h00);
        pr <= 16'h0000;
        repeat (8) @(posedge clk);
        rdc(IDX_P1_FALL, 8'h0F);
        rdc(IDX_P0_FALL, 8'h00);
        rdc(16'h0000, 8'h00);
        // A write without lane 0 must leave the latches alone
        be <= 4'h0;
        acc(1, IDX_P0_RISE, 8'h00);
        be <= 4'h1;
        rdc(IDX_P0_RISE, 8'hA5);
        acc(1, IDX_P0_RISE, 8'h5A);
        rdc(IDX_P0_RISE, 8'h00);
        acc(1, IDX_P1_FALL, 8'h00);
        repeat (4) @(posedge clk);
        chk(irq, 0);
        // Sources 0, 5, 10, 15 span both ports; one filter code each
        for (int f = 0; f < 4; f++) begin
            c = {2'b00, 2'(f), 4'(f * 5)};
            acc(1, IDX_WAKE_CFG, c | 8'h80);
            pr[f * 5] <= 1;
            repeat ((N << f) / 2) @(posedge clk);
            pr[f * 5] <= 0;
            repeat ((N << f) + 8) @(posedge clk);
            rdc(IDX_WAKE_CFG, c);
            acc(1, IDX_WAKE_CFG, c | 8'hC0);
            pr[f * 5] <= 1;
            repeat ((N << f) - 4) @(posedge clk);
            rdc(IDX_WAKE_CFG, c);
            repeat (12) @(posedge clk);
            rdc(IDX_WAKE_CFG, c | 8'h80);
            chk(wake, 1);
            pr[f * 5] <= 0;
            repeat ((N << f) + 8) @(posedge clk);
            rdc(IDX_WAKE_CFG, c | 8'hC0);
            acc(1, IDX_WAKE_CFG, c | 8'h40);
            rdc(IDX_WAKE_CFG, c | 8'h40);
            acc(1, IDX_WAKE_CFG, c);
            rdc(IDX_WAKE_CFG, c);
            chk(wake, 0);
        end
        // Reset in mid-run must bring the configuration back to zero
        rst_b <= 0;
        repeat (2) @(posedge clk);
        rst_b <= 1;
        rdc(IDX_WAKE_CFG, REG_RESET);
        conclude;
    end
endmodule
